// ---- hw/igpc_pkg.sv ----
// constants for the interleave gain and power control block
package igpc_pkg;
  localparam logic [7:0] ADDR_GAIN_COARSE = 8'h22;
  localparam logic [7:0] ADDR_GAIN_MEDIUM = 8'h23;
  localparam logic [7:0] ADDR_GAIN_FINE = 8'h24;
  localparam logic [7:0] ADDR_POWER_DOWN_SEL = 8'h25;
  localparam logic [7:0] ADDR_CORR_STATUS = 8'h30;
  localparam logic [7:0] ADDR_CORR_CONTROL = 8'h31;
  localparam logic [7:0] ADDR_CORR_STATIC = 8'h32;
  localparam logic [7:0] ADDR_CORR_POWER_DOWN = 8'h4a;
  localparam logic [7:0] ADDR_RMS_THR_LOW = 8'h50;
  localparam logic [7:0] ADDR_RMS_THR_HIGH = 8'h51;
  localparam logic [7:0] INDEX_CORE0 = 8'h01;
  localparam logic [7:0] INDEX_CORE1 = 8'h10;
  localparam logic [7:0] READ_ERROR_CODE = 8'had;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  localparam logic [3:0] COARSE_RST = 4'h0;
  localparam logic [7:0] MEDIUM_RST = 8'h80;
  localparam logic [7:0] FINE_RST = 8'h80;
  localparam logic [2:0] PMODE_PIN = 3'h0;
  localparam logic [2:0] PMODE_NORMAL = 3'h1;
  localparam logic [2:0] PMODE_NAP = 3'h2;
  localparam logic [2:0] PMODE_SLEEP = 3'h4;
  localparam logic [1:0] PIN_NORMAL = 2'h0;
  localparam logic [1:0] PIN_NAP = 2'h1;
  localparam logic [1:0] PIN_SLEEP = 2'h2;
  localparam logic [5:0] CONTROL_RST = 6'h00;
  localparam logic [1:0] CORR_PD_RST = 2'h0;
  localparam logic [15:0] RMS_THR_RST = 16'h1000;
  localparam int CTRL_ON = 0;
  localparam int CTRL_FREEZE = 1;
  localparam int CTRL_NO_OFFSET = 2;
  localparam int CTRL_NO_GAIN = 3;
  localparam int CTRL_NO_SKEW = 4;
  localparam int CTRL_NOTCH = 5;
  localparam int STATIC_SKIP = 5;
  localparam int PD_ALGO = 0;
  localparam int PD_NOTCH = 1;
  localparam logic REF_CORE = 1'b0;
  localparam int CLK_PERIOD_NS = 50;
  localparam int RMS_PERIOD_NS = 1000;
  localparam int RMS_CYCLES = RMS_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SETTLE_TIME_MS = 1000;
  localparam int SETTLE_CYCLES_DEF = SETTLE_TIME_MS * (1000000 / CLK_PERIOD_NS);
  localparam int SETTLE_W = 25;
  localparam int RMS_AVG_LOG2 = 4;
  typedef enum logic [1:0] {ENG_OFF, ENG_SETTLING, ENG_TRACKING} eng_state_t;
endpackage : igpc_pkg

// ---- hw/interleave_gain_power_control.sv ----
// gain, power-down and interleave correction control registers
// Summary of operation
// - coarse gain is four bits, each bit adding its own fixed weight
// - medium and fine gain are 8-bit codes, 0x80 meaning zero change
// - gain registers reset to a constant; calibration load and soft reset give the self-calibration result
// - power mode 000 follows the pin, other codes override it
// - register power mode hits the indexed core, pin mode the whole device
// - soft reset leaves the power mode register untouched
// - status bit 0 shows low rms power hold
// - status bit 1 shows low ac power; skew adjustment stops updating
// - status bit 2 is 0 while settling, 1 once settled
// - control bit 0 turns the engine on; writes accepted while running
// - control bit 1 freezes; clearing resumes from the kept state
// - control bits 2 to 4 disable offset, gain and skew adjustment
// - control bit 5 routes samples through the notch filter
// - static settings are taken only when the engine turns on
// - static bit 5 skips the initial coarse adjustment at turn-on
// - reference core gain is system gain; only the other core is trimmed
// - power-down bit 0 stops the algorithm, bit 1 the notch filter
// - 16-bit rms threshold at 0x50/0x51, reset 0x1000
// - samples squared, averaged, compared about every microsecond
// - threshold sits in bits 19..4 of the 24-bit compare value
// - rms hold stops gain and skew updates, offset keeps going
// - indexed registers act on the indexed core; no index reads error
module interleave_gain_power_control
  import igpc_pkg::*;
#(
  parameter int SETTLE_CYCLES = SETTLE_CYCLES_DEF
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [7:0] core_index,
  input wire logic soft_reset,
  input wire logic cal_load,
  input wire logic cal_core,
  input wire logic [3:0] cal_coarse,
  input wire logic [7:0] cal_medium,
  input wire logic [7:0] cal_fine,
  input wire logic [1:0] power_mode_pin,
  input wire logic [11:0] sample,
  input wire logic sample_valid,
  input wire logic ac_power_low,
  output logic [1:0][3:0] core_coarse_gain,
  output logic [1:0][7:0] core_medium_gain,
  output logic [1:0][7:0] core_fine_gain,
  output logic [1:0][2:0] core_power_mode,
  output logic engine_run,
  output logic coarse_start,
  output logic skip_coarse,
  output logic offset_update_en,
  output logic gain_update_en,
  output logic skew_update_en,
  output logic notch_en,
  output logic notch_power_down,
  output logic gain_trim_core
);
  logic rst_s1_q;
  logic rst_n;
  logic [1:0][3:0] coarse_q;
  logic [1:0][7:0] medium_q;
  logic [1:0][7:0] fine_q;
  logic [1:0][3:0] cal_coarse_q;
  logic [1:0][7:0] cal_medium_q;
  logic [1:0][7:0] cal_fine_q;
  logic [1:0][2:0] pmode_q;
  logic [1:0][2:0] pmode_d;
  logic [5:0] ctrl_q;
  logic static_skip_q;
  logic [1:0] corr_pd_q;
  logic [15:0] thr_q;
  logic idx_valid;
  logic idx_core;
  logic wr_ok;
  logic running;
  logic prev_on_q;
  logic turn_on;
  eng_state_t state_q;
  logic [SETTLE_W-1:0] settle_cnt_q;
  logic [4:0] us_cnt_q;
  logic us_tick;
  logic signed [11:0] samp_s;
  logic signed [23:0] sq_s;
  logic [27:0] acc_q;
  logic [27:0] acc_d;
  logic [RMS_AVG_LOG2-1:0] n_q;
  logic [23:0] avg_q;
  logic avg_ok_q;
  logic [23:0] thr24;
  logic hold_q;
  logic ac_low_q;
  logic settled;
  logic [7:0] rdata_d;

  // reset release through two flops
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  assign idx_valid = (core_index == INDEX_CORE0) ||
                     (core_index == INDEX_CORE1);
  assign idx_core = (core_index == INDEX_CORE1);
  // a soft reset cycle swallows a coincident write
  assign wr_ok = reg_wr && !soft_reset;

  // per-core indexed registers
  for (genvar c = 0; c < 2; c++) begin : g_core
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        coarse_q[c] <= COARSE_RST;
        medium_q[c] <= MEDIUM_RST;
        fine_q[c] <= FINE_RST;
        cal_coarse_q[c] <= COARSE_RST;
        cal_medium_q[c] <= MEDIUM_RST;
        cal_fine_q[c] <= FINE_RST;
      end else if (cal_load && cal_core == 1'(c)) begin
        cal_coarse_q[c] <= cal_coarse;
        cal_medium_q[c] <= cal_medium;
        cal_fine_q[c] <= cal_fine;
        coarse_q[c] <= cal_coarse;
        medium_q[c] <= cal_medium;
        fine_q[c] <= cal_fine;
      end else if (soft_reset) begin
        // soft reset default is the calibrated value, not the power-up one
        coarse_q[c] <= cal_coarse_q[c];
        medium_q[c] <= cal_medium_q[c];
        fine_q[c] <= cal_fine_q[c];
      end else if (wr_ok && idx_valid && idx_core == 1'(c)) begin
        if (reg_addr == ADDR_GAIN_COARSE) begin
          coarse_q[c] <= reg_wdata[3:0];
        end
        if (reg_addr == ADDR_GAIN_MEDIUM) begin
          medium_q[c] <= reg_wdata;
        end
        if (reg_addr == ADDR_GAIN_FINE) begin
          fine_q[c] <= reg_wdata;
        end
      end
    end

    // power mode ignores soft reset on purpose
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        pmode_q[c] <= PMODE_PIN;
      end else if (wr_ok && idx_valid && idx_core == 1'(c) &&
                   reg_addr == ADDR_POWER_DOWN_SEL) begin
        pmode_q[c] <= reg_wdata[2:0];
      end
    end

    always_comb begin
      pmode_d[c] = pmode_q[c];
      if (pmode_q[c] == PMODE_PIN) begin
        // pin mode is global: both cores decode the same pin
        unique case (power_mode_pin)
          PIN_NAP: pmode_d[c] = PMODE_NAP;
          PIN_SLEEP: pmode_d[c] = PMODE_SLEEP;
          PIN_NORMAL: pmode_d[c] = PMODE_NORMAL;
          default: pmode_d[c] = PMODE_NORMAL;
        endcase
      end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        core_power_mode[c] <= PMODE_NORMAL;
      end else begin
        core_power_mode[c] <= pmode_d[c];
      end
    end
  end

  assign core_coarse_gain = coarse_q;
  assign core_medium_gain = medium_q;
  assign core_fine_gain = fine_q;

  // global correction registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CONTROL_RST;
      static_skip_q <= 1'b0;
      corr_pd_q <= CORR_PD_RST;
      thr_q <= RMS_THR_RST;
    end else if (soft_reset) begin
      ctrl_q <= CONTROL_RST;
      static_skip_q <= 1'b0;
      corr_pd_q <= CORR_PD_RST;
      thr_q <= RMS_THR_RST;
    end else if (wr_ok) begin
      unique case (reg_addr)
        ADDR_CORR_CONTROL: ctrl_q <= reg_wdata[5:0];
        ADDR_CORR_STATIC: static_skip_q <= reg_wdata[STATIC_SKIP];
        ADDR_CORR_POWER_DOWN: corr_pd_q <= reg_wdata[1:0];
        ADDR_RMS_THR_LOW: thr_q[7:0] <= reg_wdata;
        ADDR_RMS_THR_HIGH: thr_q[15:8] <= reg_wdata;
        default: ;
      endcase
    end
  end

  assign running = ctrl_q[CTRL_ON] && !corr_pd_q[PD_ALGO];
  assign turn_on = running && !prev_on_q;

  // static options are sampled at the turn-on edge only
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prev_on_q <= 1'b0;
      skip_coarse <= 1'b0;
      coarse_start <= 1'b0;
    end else begin
      prev_on_q <= running;
      coarse_start <= turn_on && !static_skip_q;
      if (turn_on) begin
        skip_coarse <= static_skip_q;
      end
    end
  end

  // settling tracker; freeze stalls the count instead of restarting it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ENG_OFF;
      settle_cnt_q <= '0;
    end else if (!running) begin
      state_q <= ENG_OFF;
      settle_cnt_q <= '0;
    end else begin
      unique case (state_q)
        ENG_OFF: state_q <= ENG_SETTLING;
        ENG_SETTLING: begin
          if (!ctrl_q[CTRL_FREEZE]) begin
            if (settle_cnt_q == SETTLE_W'(SETTLE_CYCLES - 1)) begin
              state_q <= ENG_TRACKING;
            end else begin
              settle_cnt_q <= settle_cnt_q + 1'b1;
            end
          end
        end
        ENG_TRACKING: state_q <= ENG_TRACKING;
      endcase
    end
  end

  assign settled = (state_q == ENG_TRACKING);

  // one-microsecond compare enable
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      us_cnt_q <= '0;
    end else if (us_cnt_q == 5'(RMS_CYCLES - 1)) begin
      us_cnt_q <= '0;
    end else begin
      us_cnt_q <= us_cnt_q + 1'b1;
    end
  end

  assign us_tick = (us_cnt_q == 5'(RMS_CYCLES - 1));

  // rms meter: fixed block of squares stands in for the dynamic average
  assign samp_s = sample;
  assign sq_s = samp_s * samp_s;
  assign acc_d = acc_q + {4'h0, sq_s};

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= '0;
      n_q <= '0;
      avg_q <= '0;
      avg_ok_q <= 1'b0;
    end else if (!running) begin
      acc_q <= '0;
      n_q <= '0;
      avg_ok_q <= 1'b0;
    end else if (sample_valid) begin
      n_q <= n_q + 1'b1;
      if (n_q == '1) begin
        avg_q <= acc_d[RMS_AVG_LOG2 +: 24];
        avg_ok_q <= 1'b1;
        acc_q <= '0;
      end else begin
        acc_q <= acc_d;
      end
    end
  end

  assign thr24 = {4'h0, thr_q, 4'h0};

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q <= 1'b0;
      ac_low_q <= 1'b0;
    end else begin
      ac_low_q <= running && ac_power_low;
      if (!running) begin
        hold_q <= 1'b0;
      end else if (us_tick && avg_ok_q) begin
        hold_q <= (avg_q < thr24);
      end
    end
  end

  // update enables toward the analog trims
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      engine_run <= 1'b0;
      offset_update_en <= 1'b0;
      gain_update_en <= 1'b0;
      skew_update_en <= 1'b0;
      notch_en <= 1'b0;
      notch_power_down <= 1'b0;
      gain_trim_core <= !REF_CORE;
    end else begin
      engine_run <= running && !ctrl_q[CTRL_FREEZE];
      offset_update_en <= running && !ctrl_q[CTRL_FREEZE] &&
                          !ctrl_q[CTRL_NO_OFFSET];
      gain_update_en <= running && !ctrl_q[CTRL_FREEZE] &&
                        !ctrl_q[CTRL_NO_GAIN] && !hold_q;
      skew_update_en <= running && !ctrl_q[CTRL_FREEZE] &&
                        !ctrl_q[CTRL_NO_SKEW] && !hold_q &&
                        !ac_low_q;
      notch_en <= ctrl_q[CTRL_NOTCH] && !corr_pd_q[PD_NOTCH];
      notch_power_down <= corr_pd_q[PD_NOTCH];
      gain_trim_core <= !REF_CORE;
    end
  end

  // read port, one cycle latency
  always_comb begin
    rdata_d = READ_UNMAPPED;
    unique case (reg_addr)
      ADDR_GAIN_COARSE: rdata_d = {4'h0, coarse_q[idx_core]};
      ADDR_GAIN_MEDIUM: rdata_d = medium_q[idx_core];
      ADDR_GAIN_FINE: rdata_d = fine_q[idx_core];
      ADDR_POWER_DOWN_SEL: rdata_d = {5'h00, pmode_q[idx_core]};
      ADDR_CORR_STATUS: rdata_d = {5'h00, settled, ac_low_q,
                                   hold_q};
      ADDR_CORR_CONTROL: rdata_d = {2'h0, ctrl_q};
      ADDR_CORR_STATIC: rdata_d = {2'h0, static_skip_q, 5'h00};
      ADDR_CORR_POWER_DOWN: rdata_d = {6'h00, corr_pd_q};
      ADDR_RMS_THR_LOW: rdata_d = thr_q[7:0];
      ADDR_RMS_THR_HIGH: rdata_d = thr_q[15:8];
      default: rdata_d = READ_UNMAPPED;
    endcase
    if (!idx_valid && reg_addr >= ADDR_GAIN_COARSE &&
        reg_addr <= ADDR_POWER_DOWN_SEL) begin
      rdata_d = READ_ERROR_CODE;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_d;
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  coarse_write_a: assert property (wr_ok && !cal_load &&
    core_index == INDEX_CORE0 && reg_addr == ADDR_GAIN_COARSE
    |=> coarse_q[0] == $past(reg_wdata[3:0]))
    else $error("coarse gain write lost");
  medium_write_a: assert property (wr_ok && !cal_load &&
    core_index == INDEX_CORE1 && reg_addr == ADDR_GAIN_MEDIUM
    |=> medium_q[1] == $past(reg_wdata))
    else $error("medium gain write lost");
  cal_load_a: assert property (cal_load && !cal_core
    |=> fine_q[0] == $past(cal_fine) && cal_fine_q[0] == $past(cal_fine))
    else $error("calibration value not loaded");
  mode_override_a: assert property (pmode_q[1] != PMODE_PIN
    |=> core_power_mode[1] == $past(pmode_q[1]))
    else $error("register mode did not override pin");
  mode_index_a: assert property (reg_wr &&
    core_index == INDEX_CORE0 |=> pmode_q[1] == $past(pmode_q[1]))
    else $error("power mode hit unselected core");
  soft_keep_a: assert property (soft_reset |=> $stable(pmode_q))
    else $error("soft reset changed power mode");
  status_read_a: assert property (reg_rd &&
    reg_addr == ADDR_CORR_STATUS
    |=> reg_rvalid && reg_rdata[2:0] == $past({settled, ac_low_q, hold_q}))
    else $error("status read mismatch");
  settle_time_a: assert property (turn_on && !ctrl_q[CTRL_FREEZE]
    |=> !settled[*2])
    else $error("settled too early");
  off_clear_a: assert property (!running |=> !settled)
    else $error("settled flag survived turn-off");
  static_latch_a: assert property (turn_on
    |=> skip_coarse == $past(static_skip_q) &&
        coarse_start == !$past(static_skip_q))
    else $error("static option not taken at turn-on");
  hold_gates_a: assert property (hold_q && running &&
    !ctrl_q[CTRL_FREEZE] && !ctrl_q[CTRL_NO_OFFSET]
    |=> !gain_update_en && !skew_update_en && offset_update_en)
    else $error("rms hold gating wrong");
  index_error_a: assert property (reg_rd && !idx_valid &&
    reg_addr == ADDR_GAIN_FINE |=> reg_rdata == READ_ERROR_CODE)
    else $error("missing index error code");

  turn_on_c: cover property (turn_on ##1 !settled);
  hold_c: cover property (running && us_tick && avg_ok_q ##1 hold_q);
  settled_c: cover property ($rose(settled));
  error_read_c: cover property (reg_rvalid && reg_rdata == READ_ERROR_CODE);
endmodule // interleave_gain_power_control

// ---- verification/config_host.sv ----
// host model driving the block's register access strobes
module config_host
  import igpc_pkg::*;
(
  input wire logic mclk,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] core_index
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    core_index = 8'h00;
  end

  // one strobe cycle per write; data is inverted once released so a
  // design that samples late sees garbage instead of a stale match
  task automatic wr(input logic [7:0] idx, input logic [7:0] a,
                    input logic [7:0] dat);
    @(posedge mclk);
    core_index <= idx;
    reg_addr <= a;
    // static bits other than 0, 5 and 6 are always sent as zero
    reg_wdata <= (a == ADDR_CORR_STATIC) ? (dat & 8'h61) : dat;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_wdata <= ~dat;
    #1;
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] a,
                    output logic [7:0] d);
    @(posedge mclk);
    core_index <= idx;
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rvalid ? reg_rdata : 8'hxx;
  endtask
endmodule // config_host

// ---- verification/interleave_gain_power_control_tb.sv ----
// self-checking bench for the interleave gain and power control block
`define CHK(got, exp) begin \
  samples_checked++; \
  if ((got) !== (exp)) begin \
    err_total++; \
    $display("Error t=%0t got=%h exp=%h", $time, got, exp); \
  end \
end
module interleave_gain_power_control_tb;
  import igpc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SETTLE = 20;
  localparam logic [2:0] PIN_EXP [4] = '{PMODE_NORMAL, PMODE_NAP,
                                         PMODE_SLEEP, PMODE_NORMAL};
  localparam logic [2:0] REG_MODE [4] = '{PMODE_NORMAL, PMODE_NAP,
                                          PMODE_SLEEP, PMODE_PIN};
  localparam logic [15:0] THR [2] = '{16'h1000, 16'h0010};
  localparam logic [11:0] S_LO [2] = '{12'h0ff, 12'h00f};
  localparam logic [11:0] S_HI [2] = '{12'hf00, 12'h010};
  logic mclk, arst_n, reg_wr, reg_rd, reg_rvalid, soft_reset, cal_load;
  logic cal_core, ac_power_low, engine_run, coarse_start, skip_coarse;
  logic offset_update_en, gain_update_en, skew_update_en, notch_en;
  logic notch_power_down, gain_trim_core, seen;
  logic sample_valid = 1'b0;
  logic [11:0] sample = 12'h000;
  logic [11:0] level;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, core_index, cal_medium;
  logic [7:0] cal_fine, ctl;
  logic [3:0] cal_coarse;
  logic [1:0] power_mode_pin;
  logic [1:0][3:0] core_coarse_gain;
  logic [1:0][7:0] core_medium_gain, core_fine_gain;
  logic [1:0][2:0] core_power_mode;
  int err_total, samples_checked, cycles;

  config_host u_config_host (.mclk(mclk), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .core_index(core_index));

  // short settle count keeps the run to a few hundred cycles
  interleave_gain_power_control #(.SETTLE_CYCLES(SETTLE))
    u_interleave_gain_power_control (.mclk(mclk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .core_index(core_index), .soft_reset(soft_reset),
    .cal_load(cal_load), .cal_core(cal_core), .cal_coarse(cal_coarse),
    .cal_medium(cal_medium), .cal_fine(cal_fine),
    .power_mode_pin(power_mode_pin), .sample(sample),
    .sample_valid(sample_valid), .ac_power_low(ac_power_low),
    .core_coarse_gain(core_coarse_gain),
    .core_medium_gain(core_medium_gain), .core_fine_gain(core_fine_gain),
    .core_power_mode(core_power_mode), .engine_run(engine_run),
    .coarse_start(coarse_start), .skip_coarse(skip_coarse),
    .offset_update_en(offset_update_en), .gain_update_en(gain_update_en),
    .skew_update_en(skew_update_en), .notch_en(notch_en),
    .notch_power_down(notch_power_down), .gain_trim_core(gain_trim_core));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // free-running sample stream; level picks the input power
  always @(posedge mclk) begin
    sample <= level;
    sample_valid <= 1'b1;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks=%0d errors=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] a,
                    input logic [7:0] d);
    u_config_host.wr(idx, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] a,
                        input logic [7:0] e, input logic [7:0] m);
    logic [7:0] d;
    u_config_host.rd(idx, a, d);
    `CHK(d & m, e & m)
  endtask

  task automatic cal(input logic c, input logic [3:0] co,
                     input logic [7:0] me, input logic [7:0] fi);
    @(posedge mclk);
    cal_load <= 1'b1;
    cal_core <= c;
    cal_coarse <= co;
    cal_medium <= me;
    cal_fine <= fi;
    @(posedge mclk);
    cal_load <= 1'b0;
  endtask

  initial begin
    arst_n = 1'b0;
    soft_reset = 1'b0;
    cal_load = 1'b0;
    cal_core = 1'b0;
    cal_coarse = 4'h0;
    cal_medium = 8'h00;
    cal_fine = 8'h00;
    power_mode_pin = PIN_NORMAL;
    ac_power_low = 1'b0;
    level = 12'h7ff;
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    cyc(3);
    `CHK(core_power_mode[1], PMODE_NORMAL)
    `CHK(gain_trim_core, 1'b1)
    cal(1'b0, 4'h3, 8'h11, 8'h22);
    cal(1'b1, 4'hc, 8'h33, 8'h44);
    rd_chk(INDEX_CORE0, ADDR_GAIN_MEDIUM, 8'h11, 8'hff);
    rd_chk(INDEX_CORE1, ADDR_GAIN_FINE, 8'h44, 8'hff);
    rd_chk(INDEX_CORE1, ADDR_GAIN_COARSE, 8'h0c, 8'h0f);
    wr(INDEX_CORE1, ADDR_GAIN_COARSE, 8'h05);
    wr(INDEX_CORE1, ADDR_GAIN_MEDIUM, 8'hff);
    wr(INDEX_CORE1, ADDR_GAIN_FINE, 8'h00);
    `CHK(core_coarse_gain[1], 4'h5)
    `CHK(core_coarse_gain[0], 4'h3)
    `CHK({core_medium_gain[1], core_fine_gain[1]}, 16'hff00)
    wr(8'h00, ADDR_GAIN_MEDIUM, 8'h80);
    `CHK(core_medium_gain[1], 8'hff)
    rd_chk(8'h00, ADDR_GAIN_MEDIUM, READ_ERROR_CODE, 8'hff);
    rd_chk(INDEX_CORE0, 8'h7f, READ_UNMAPPED, 8'hff);
    for (int p = 0; p < 4; p++) begin
      power_mode_pin <= p[1:0];
      cyc(2);
      `CHK(core_power_mode, {PIN_EXP[p], PIN_EXP[p]})
    end
    power_mode_pin <= PIN_NAP;
    for (int m = 0; m < 4; m++) begin
      wr(INDEX_CORE0, ADDR_POWER_DOWN_SEL, {5'h00, REG_MODE[m]});
      cyc(2);
      ctl = (m == 3) ? {5'h00, PMODE_NAP} : {5'h00, REG_MODE[m]};
      `CHK(core_power_mode[0], ctl[2:0])
      `CHK(core_power_mode[1], PMODE_NAP)
    end
    wr(INDEX_CORE0, ADDR_POWER_DOWN_SEL, {5'h00, PMODE_SLEEP});
    wr(INDEX_CORE0, ADDR_RMS_THR_LOW, 8'h34);
    @(posedge mclk);
    soft_reset <= 1'b1;
    @(posedge mclk);
    soft_reset <= 1'b0;
    cyc(2);
    `CHK(core_power_mode[0], PMODE_SLEEP)
    `CHK(core_medium_gain[1], 8'h33)
    rd_chk(INDEX_CORE0, ADDR_POWER_DOWN_SEL, 8'h04, 8'h07);
    rd_chk(INDEX_CORE0, ADDR_RMS_THR_LOW, 8'h00, 8'hff);
    rd_chk(INDEX_CORE0, ADDR_RMS_THR_HIGH, 8'h10, 8'hff);
    wr(INDEX_CORE0, ADDR_POWER_DOWN_SEL, {5'h00, PMODE_PIN});
    power_mode_pin <= PIN_NORMAL;
    // static word first: it is only taken at turn-on
    wr(INDEX_CORE0, ADDR_CORR_STATIC, 8'h20);
    wr(INDEX_CORE0, ADDR_CORR_CONTROL, 8'h01);
    cyc(1);
    `CHK({engine_run, skip_coarse}, 2'b11)
    rd_chk(INDEX_CORE0, ADDR_CORR_STATUS, 8'h00, 8'h04);
    cyc(SETTLE + 5);
    rd_chk(INDEX_CORE0, ADDR_CORR_STATUS, 8'h04, 8'h04);
    wr(INDEX_CORE0, ADDR_CORR_CONTROL, 8'h03);
    cyc(2);
    `CHK(engine_run, 1'b0)
    wr(INDEX_CORE0, ADDR_CORR_CONTROL, 8'h01);
    cyc(2);
    `CHK(engine_run, 1'b1)
    rd_chk(INDEX_CORE0, ADDR_CORR_STATUS, 8'h04, 8'h04);
    cyc(40);
    for (int b = 1; b < 8; b++) begin
      ctl = {3'h0, b[2:0], 2'h1};
      wr(INDEX_CORE0, ADDR_CORR_CONTROL, ctl);
      cyc(2);
      `CHK({skew_update_en, gain_update_en, offset_update_en}, ~ctl[4:2])
    end
    wr(INDEX_CORE0, ADDR_CORR_CONTROL, 8'h21);
    cyc(2);
    `CHK(notch_en, 1'b1)
    rd_chk(INDEX_CORE0, ADDR_CORR_CONTROL, 8'h21, 8'h3f);
    wr(INDEX_CORE0, ADDR_CORR_CONTROL, 8'h01);
    cyc(2);
    `CHK(notch_en, 1'b0)
    wr(INDEX_CORE0, ADDR_CORR_STATIC, 8'h00);
    cyc(2);
    `CHK(skip_coarse, 1'b1)
    wr(INDEX_CORE0, ADDR_CORR_POWER_DOWN, 8'h02);
    cyc(2);
    `CHK(notch_power_down, 1'b1)
    wr(INDEX_CORE0, ADDR_CORR_POWER_DOWN, 8'h01);
    cyc(2);
    `CHK(engine_run, 1'b0)
    rd_chk(INDEX_CORE0, ADDR_CORR_STATUS, 8'h00, 8'h04);
    wr(INDEX_CORE0, ADDR_CORR_POWER_DOWN, 8'h00);
    seen = 1'b0;
    repeat (4) begin
      cyc(1);
      seen |= (coarse_start === 1'b1);
    end
    `CHK({seen, skip_coarse}, 2'b10)
    // equal power sits on the boundary and must not hold
    for (int t = 0; t < 2; t++) begin
      wr(INDEX_CORE0, ADDR_RMS_THR_LOW, THR[t][7:0]);
      wr(INDEX_CORE0, ADDR_RMS_THR_HIGH, THR[t][15:8]);
      level <= S_LO[t];
      // a clean 16-sample block plus a compare tick can take 53 cycles
      cyc(60);
      rd_chk(INDEX_CORE0, ADDR_CORR_STATUS, 8'h01, 8'h01);
      `CHK({skew_update_en, gain_update_en, offset_update_en}, 3'b001)
      level <= S_HI[t];
      cyc(60);
      rd_chk(INDEX_CORE0, ADDR_CORR_STATUS, 8'h00, 8'h01);
      `CHK({skew_update_en, gain_update_en, offset_update_en}, 3'b111)
    end
    ac_power_low <= 1'b1;
    cyc(3);
    rd_chk(INDEX_CORE0, ADDR_CORR_STATUS, 8'h02, 8'h02);
    ac_power_low <= 1'b0;
    cyc(3);
    rd_chk(INDEX_CORE0, ADDR_CORR_STATUS, 8'h00, 8'h02);
    end_of_test();
  end
endmodule // interleave_gain_power_control_tb
